/* File: src/sup_pkg.sv */
// constants, codes and state types of the supervisor block
package sup_pkg;

    // ----------------------------------------------------------------
    // clock and time base
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 8;
    localparam int TICK_PERIOD_US  = 1000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int TB_CNT_W        = 20;

    // ----------------------------------------------------------------
    // timeouts in ms and in ticks, power-fail delay in ns and in clock cycles
    // ----------------------------------------------------------------
    localparam int TCNT_W           = 12;
    localparam int WD_TIMEOUT_MS    = 280;
    localparam int RST_TIMEOUT_MS   = 200;
    localparam logic [TCNT_W-1:0] WD_FIXED_TICKS  = TCNT_W'(WD_TIMEOUT_MS * 1000 / TICK_PERIOD_US);
    localparam logic [TCNT_W-1:0] RST_FIXED_TICKS = TCNT_W'(RST_TIMEOUT_MS * 1000 / TICK_PERIOD_US);
    localparam int PF_DELAY_NS      = 35000;
    localparam int PF_CYCLES_DEF    = PF_DELAY_NS / CLK_PERIOD_NS;
    localparam int PF_CNT_W         = 20;

    // ----------------------------------------------------------------
    // period-select and window-select codes
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_GND   = 2'h0;
    localparam logic [1:0] SEL_FIXED = 2'h1;
    localparam logic [1:0] SEL_ADJ   = 2'h2;
    localparam logic [1:0] WIN_R8    = 2'h0;
    localparam logic [1:0] WIN_OFF   = 2'h1;
    localparam logic [1:0] WIN_R16   = 2'h2;
    localparam logic [1:0] WIN_R64   = 2'h3;
    localparam int SHIFT_R8  = 3;
    localparam int SHIFT_R16 = 4;
    localparam int SHIFT_R64 = 6;

    // ----------------------------------------------------------------
    // synchroniser bit map and reset values
    // ----------------------------------------------------------------
    localparam int B_KICK   = 0;
    localparam int B_RGOOD  = 1;
    localparam int B_SENSE  = 2;
    localparam int B_EN1    = 3;
    localparam int B_EN2    = 4;
    localparam int B_KEEPN  = 5;
    localparam int B_WDOFFN = 6;
    localparam int B_WSEL   = 7;
    localparam int B_WPSEL  = 9;
    localparam int B_RPSEL  = 11;
    localparam int B_WADJ   = 13;
    localparam int B_RADJ   = 25;
    localparam int SYNC_W   = 37;
    localparam logic [SYNC_W-1:0] SYNC_RST = 37'h0000000060;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b10
    } rst_state_t;

endpackage

/* File: src/sup_sig_if.sv */
// synchronised pins, kick edge and time-base tick
`timescale 1ns/1ps
`default_nettype none
interface sup_sig_if;
    import sup_pkg::*;
    logic [SYNC_W-1:0] s;
    logic              kick_edge;
    logic              tick;
    modport sync_side (output s, output kick_edge);
    modport tick_side (output tick);
    modport core      (input s, input kick_edge, input tick);
endinterface
`default_nettype wire

/* File: src/input_sync.sv */
// two-flop synchronisers for all pins and kick edge detect
`timescale 1ns/1ps
`default_nettype none
module input_sync
    import sup_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              rst_b_in,
    input  wire logic [SYNC_W-1:0] raw_in,
    sup_sig_if.sync_side           sig
);
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] sync_d;
    logic              kick_prev_q;

    // ----------------------------------------------------------------
    // per-bit synchroniser
    // ----------------------------------------------------------------
    for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
        always_ff @(posedge clock_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                meta_q[i] <= SYNC_RST[i];
                sync_q[i] <= SYNC_RST[i];
            end else begin
                meta_q[i] <= raw_in[i];
                sync_q[i] <= sync_d[i];
            end
        end
    end

    always_comb begin
        sync_d = meta_q;
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            kick_prev_q <= 1'b0;
        end else begin
            kick_prev_q <= sync_q[B_KICK];
        end
    end

    assign sig.kick_edge = sync_q[B_KICK] ^ kick_prev_q;
    assign sig.s         = sync_q;
endmodule
`default_nettype wire

/* File: src/time_base.sv */
// slow time-base tick divider
`timescale 1ns/1ps
`default_nettype none
module time_base
    import sup_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic    clock_in,
    input  wire logic    rst_b_in,
    sup_sig_if.tick_side sig
);
    localparam logic [TB_CNT_W-1:0] TB_LAST = TB_CNT_W'(TICK_CYCLES - 1);

    logic [TB_CNT_W-1:0] div_q;
    logic [TB_CNT_W-1:0] div_d;
    logic                tick_q;
    logic                tick_d;

    always_comb begin
        tick_d = (div_q == TB_LAST);
        div_d  = tick_d ? '0 : div_q + 1'b1;
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign sig.tick = tick_q;
endmodule
`default_nettype wire

/* File: src/supervisor_watchdog_hold_ctrl.sv */
// supervisor top: watchdog, reset generator, rail hold, power-fail flag
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_hold_ctrl
    import sup_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int PF_CYCLES   = PF_CYCLES_DEF,
    parameter bit WINDOWED    = 1'b0
) (
    input  wire logic              clock_in,
    input  wire logic              rst_b_in,
    input  wire logic              wdog_kick_in,
    input  wire logic              rail1_good_in,
    input  wire logic              supply_sense_in,
    input  wire logic              rail1_on_in,
    input  wire logic              rail2_on_in,
    input  wire logic              keep_on_n_in,
    input  wire logic              wdog_off_n_in,
    input  wire logic              window_select_lo_in,
    input  wire logic              window_select_hi_in,
    input  wire logic [1:0]        wdog_period_sel_in,
    input  wire logic [1:0]        rst_period_sel_in,
    input  wire logic [TCNT_W-1:0] wdog_adj_ticks_in,
    input  wire logic [TCNT_W-1:0] rst_adj_ticks_in,
    output logic                   reset_n_out,
    output logic                   rail1_out,
    output logic                   rail2_out,
    output logic                   supply_fail_n_out
);
    localparam logic [PF_CNT_W-1:0] PF_LAST = PF_CNT_W'(PF_CYCLES - 1);

    // ----------------------------------------------------------------
    // pin synchronisers and time base
    // ----------------------------------------------------------------
    sup_sig_if         sig ();
    logic [SYNC_W-1:0] raw;

    assign raw[B_KICK]            = wdog_kick_in;
    assign raw[B_RGOOD]           = rail1_good_in;
    assign raw[B_SENSE]           = supply_sense_in;
    assign raw[B_EN1]             = rail1_on_in;
    assign raw[B_EN2]             = rail2_on_in;
    assign raw[B_KEEPN]           = keep_on_n_in;
    assign raw[B_WDOFFN]          = wdog_off_n_in;
    assign raw[B_WSEL]            = window_select_lo_in;
    assign raw[B_WSEL+1]          = window_select_hi_in;
    assign raw[B_WPSEL +: 2]      = wdog_period_sel_in;
    assign raw[B_RPSEL +: 2]      = rst_period_sel_in;
    assign raw[B_WADJ +: TCNT_W]  = wdog_adj_ticks_in;
    assign raw[B_RADJ +: TCNT_W]  = rst_adj_ticks_in;

    input_sync u_sync (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .raw_in   (raw),
        .sig      (sig.sync_side)
    );

    time_base #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .sig      (sig.tick_side)
    );

    logic              tick;
    logic              kick_edge;
    logic              rail_good;
    logic              sense_ok;
    logic              en1;
    logic              en2;
    logic              keep_n;
    logic              wd_off_n;
    logic [1:0]        win_sel;
    logic [1:0]        wp_sel;
    logic [1:0]        rp_sel;
    logic [TCNT_W-1:0] wd_adj;
    logic [TCNT_W-1:0] rst_adj;

    assign tick      = sig.tick;
    assign kick_edge = sig.kick_edge;
    assign rail_good = sig.s[B_RGOOD];
    assign sense_ok  = sig.s[B_SENSE];
    assign en1       = sig.s[B_EN1];
    assign en2       = sig.s[B_EN2];
    assign keep_n    = sig.s[B_KEEPN];
    assign wd_off_n  = sig.s[B_WDOFFN];
    assign win_sel   = sig.s[B_WSEL +: 2];
    assign wp_sel    = sig.s[B_WPSEL +: 2];
    assign rp_sel    = sig.s[B_RPSEL +: 2];
    assign wd_adj    = sig.s[B_WADJ +: TCNT_W];
    assign rst_adj   = sig.s[B_RADJ +: TCNT_W];

    // ----------------------------------------------------------------
    // watchdog limits and disable
    // ----------------------------------------------------------------
    logic [TCNT_W-1:0] wd_limit;
    logic [TCNT_W-1:0] win_min;
    logic [TCNT_W-1:0] rst_limit;
    logic              wd_disabled;
    logic              rst_gnd;

    always_comb begin
        wd_limit  = (wp_sel == SEL_ADJ) ? wd_adj : WD_FIXED_TICKS;
        rst_limit = (rp_sel == SEL_ADJ) ? rst_adj : RST_FIXED_TICKS;
        rst_gnd   = (rp_sel == SEL_GND);
        unique case (win_sel)
            WIN_R16: win_min = wd_limit >> SHIFT_R16;
            WIN_R64: win_min = wd_limit >> SHIFT_R64;
            default: win_min = wd_limit >> SHIFT_R8;
        endcase
        if (WINDOWED) begin
            wd_disabled = (wp_sel == SEL_GND) || (win_sel == WIN_OFF);
        end else begin
            wd_disabled = (wp_sel == SEL_GND) || !wd_off_n;
        end
    end

    // ----------------------------------------------------------------
    // watchdog counter
    // ----------------------------------------------------------------
    logic [TCNT_W-1:0] wd_cnt_q;
    logic [TCNT_W-1:0] wd_cnt_d;
    logic              wd_fault;
    logic              reset_n_q;

    always_comb begin
        wd_cnt_d = wd_cnt_q;
        wd_fault = 1'b0;
        if (!reset_n_q || wd_disabled) begin
            wd_cnt_d = '0;
        end else if (kick_edge) begin
            if (WINDOWED && (wd_cnt_q < win_min)) begin
                wd_fault = 1'b1;
            end
            wd_cnt_d = '0;
        end else if (wd_cnt_q >= wd_limit) begin
            wd_fault = 1'b1;
        end else if (tick) begin
            wd_cnt_d = wd_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wd_cnt_q <= '0;
        end else begin
            wd_cnt_q <= wd_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // reset generator
    // ----------------------------------------------------------------
    rst_state_t        state_q;
    rst_state_t        state_d;
    logic [TCNT_W-1:0] rst_cnt_q;
    logic [TCNT_W-1:0] rst_cnt_d;
    logic              reset_n_d;

    always_comb begin
        state_d   = state_q;
        rst_cnt_d = rst_cnt_q;
        unique case (state_q)
            ST_RUN: begin
                if (!rail_good || rst_gnd || wd_fault) begin
                    state_d   = ST_HOLD;
                    rst_cnt_d = '0;
                end
            end
            ST_HOLD: begin
                // held until rail good and reset select not grounded, then timed
                if (!rail_good || rst_gnd) begin
                    rst_cnt_d = '0;
                end else if (rst_cnt_q >= rst_limit) begin
                    state_d = ST_RUN;
                end else if (tick) begin
                    rst_cnt_d = rst_cnt_q + 1'b1;
                end
            end
            default: begin
                state_d   = ST_HOLD;
                rst_cnt_d = '0;
            end
        endcase
        reset_n_d = (state_d == ST_RUN);
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q   <= ST_HOLD;
            rst_cnt_q <= '0;
            reset_n_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            rst_cnt_q <= rst_cnt_d;
            reset_n_q <= reset_n_d;
        end
    end

    // ----------------------------------------------------------------
    // rail enables, self-hold and power-fail flag
    // ----------------------------------------------------------------
    logic                rail1_q;
    logic                rail1_d;
    logic                rail2_q;
    logic                rail2_d;
    logic                pf_q;
    logic                pf_d;
    logic [PF_CNT_W-1:0] pf_cnt_q;
    logic [PF_CNT_W-1:0] pf_cnt_d;

    always_comb begin
        rail1_d = en1 || (rail1_q && !keep_n);
        rail2_d = en2;
        pf_d     = pf_q;
        pf_cnt_d = '0;
        if (sense_ok != pf_q) begin
            if (pf_cnt_q >= PF_LAST) begin
                pf_d = sense_ok;
            end else begin
                pf_cnt_d = pf_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rail1_q  <= 1'b0;
            rail2_q  <= 1'b0;
            pf_q     <= 1'b0;
            pf_cnt_q <= '0;
        end else begin
            rail1_q  <= rail1_d;
            rail2_q  <= rail2_d;
            pf_q     <= pf_d;
            pf_cnt_q <= pf_cnt_d;
        end
    end

    assign reset_n_out       = reset_n_q;
    assign rail1_out         = rail1_q;
    assign rail2_out         = rail2_q;
    assign supply_fail_n_out = pf_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    property p_fault_reset;
        wd_fault |=> !reset_n_out && (state_q == ST_HOLD) && (rst_cnt_q == '0);
    endproperty
    a_fault_reset: assert property (p_fault_reset)
        else $error("watchdog fault did not assert reset");

    property p_cnt_clear;
        !reset_n_out |=> (wd_cnt_q == '0);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear)
        else $error("watchdog counter not cleared by reset");

    property p_hold_full;
        (state_q == ST_HOLD) && (rst_cnt_q < rst_limit) |=> !reset_n_out;
    endproperty
    a_hold_full: assert property (p_hold_full)
        else $error("reset released before timeout");

    property p_resume_zero;
        $rose(reset_n_out) |-> (wd_cnt_q == '0) && !wd_fault;
    endproperty
    a_resume_zero: assert property (p_resume_zero)
        else $error("watchdog did not restart from zero");

    property p_window_fast;
        WINDOWED && reset_n_out && !wd_disabled && kick_edge && (wd_cnt_q < win_min)
            |=> !reset_n_out;
    endproperty
    a_window_fast: assert property (p_window_fast)
        else $error("early kick edge not faulted");

    property p_wd_gnd;
        (wp_sel == SEL_GND) |-> !wd_fault;
    endproperty
    a_wd_gnd: assert property (p_wd_gnd)
        else $error("grounded period select still faults");

    property p_uv_reset;
        !rail_good |=> !reset_n_out ##1 !reset_n_out;
    endproperty
    a_uv_reset: assert property (p_uv_reset)
        else $error("undervoltage did not hold reset low");

    property p_release_time;
        $rose(reset_n_out) |-> $past(rst_cnt_q) >= $past(rst_limit) && $past(rail_good);
    endproperty
    a_release_time: assert property (p_release_time)
        else $error("reset rose without full timeout");

    property p_rail2;
        1'b1 |=> rail2_out == $past(en2);
    endproperty
    a_rail2: assert property (p_rail2)
        else $error("rail 2 does not follow its enable");

    property p_self_hold;
        rail1_out && !keep_n && !en1 |=> rail1_out;
    endproperty
    a_self_hold: assert property (p_self_hold)
        else $error("rail 1 dropped while held");

    property p_release_hold;
        !en1 && keep_n |=> !rail1_out;
    endproperty
    a_release_hold: assert property (p_release_hold)
        else $error("rail 1 stays on after keep-on release");

    property p_pf_delay;
        $changed(supply_fail_n_out) |-> $past(pf_cnt_q) == PF_LAST;
    endproperty
    a_pf_delay: assert property (p_pf_delay)
        else $error("supply-fail flag moved without delay");

    property p_gnd_reset;
        rst_gnd |=> !reset_n_out;
    endproperty
    a_gnd_reset: assert property (p_gnd_reset)
        else $error("grounded reset select did not hold reset");

    c_wd_fault: cover property (reset_n_out && wd_fault);
    c_release:  cover property ($rose(reset_n_out));
    c_hold:     cover property (rail1_out && !en1 && !keep_n);
    c_pf_fall:  cover property ($fell(supply_fail_n_out));
endmodule
`default_nettype wire

/* File: tb/host_model.sv */
// host model: toggles the kick pin at a set gap while reset and run are high
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    input  wire logic       run_in,
    input  wire logic [7:0] gap_in,
    output var  logic       kick_out
);
    logic [7:0] cnt_q;
    initial begin
        kick_out = 1'b0;
        cnt_q    = 8'h00;
    end
    always @(posedge clock_in) begin
        cnt_q <= (reset_n_in && run_in) ? cnt_q + 8'h01 : 8'h00;
        if (reset_n_in && run_in && cnt_q >= gap_in) begin
            cnt_q    <= 8'h00;
            kick_out <= ~kick_out;
        end
    end
endmodule
`default_nettype wire

/* File: tb/supervisor_watchdog_hold_ctrl_tb.sv */
// self-checking bench: plain and windowed instances sharing all input pins
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_hold_ctrl_tb;
    import sup_pkg::*;
    typedef struct {int idx; logic val;} note_t;
    logic clock_in, rst_b_in, wdog_kick_in, rail1_good_in, supply_sense_in;
    logic rail1_on_in, rail2_on_in, keep_on_n_in, wdog_off_n_in;
    logic window_select_lo_in, window_select_hi_in, run, r1m;
    logic [1:0] wdog_period_sel_in, rst_period_sel_in;
    logic [TCNT_W-1:0] wdog_adj_ticks_in, rst_adj_ticks_in;
    logic [7:0] gap;
    logic rn, r1, r2, pf, rnw;
    logic [4:0] outs;
    int num_errors, samples_checked, cyc;
    note_t notes[$];
    event chk_ev;
    string nm[5] = '{"reset_n", "rail1", "rail2", "supply_fail_n", "win_reset_n"};
    assign outs = {rnw, pf, r2, r1, rn};

    supervisor_watchdog_hold_ctrl #(.TICK_CYCLES(16), .PF_CYCLES(8), .WINDOWED(1'b0))
    i_supervisor_watchdog_hold_ctrl (.clock_in, .rst_b_in, .wdog_kick_in, .rail1_good_in,
        .supply_sense_in, .rail1_on_in, .rail2_on_in, .keep_on_n_in, .wdog_off_n_in,
        .window_select_lo_in, .window_select_hi_in, .wdog_period_sel_in,
        .rst_period_sel_in, .wdog_adj_ticks_in, .rst_adj_ticks_in, .reset_n_out(rn),
        .rail1_out(r1), .rail2_out(r2), .supply_fail_n_out(pf));
    supervisor_watchdog_hold_ctrl #(.TICK_CYCLES(16), .PF_CYCLES(8), .WINDOWED(1'b1))
    i_win (.clock_in, .rst_b_in, .wdog_kick_in, .rail1_good_in,
        .supply_sense_in, .rail1_on_in, .rail2_on_in, .keep_on_n_in, .wdog_off_n_in,
        .window_select_lo_in, .window_select_hi_in, .wdog_period_sel_in,
        .rst_period_sel_in, .wdog_adj_ticks_in, .rst_adj_ticks_in, .reset_n_out(rnw),
        .rail1_out(), .rail2_out(), .supply_fail_n_out());
    host_model i_host_model (.clock_in, .reset_n_in(rn), .run_in(run), .gap_in(gap),
        .kick_out(wdog_kick_in));

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic expect_out(input int idx, input logic val);
        @(negedge clock_in);
        notes.push_back('{idx, val});
        ->chk_ev;
        @(posedge clock_in);
    endtask
    task automatic tk(input int n);
        repeat (n * 16) @(posedge clock_in);
    endtask
    task automatic wait_low();
        for (int i = 0; i < 400 && rn !== 1'b0; i++) @(posedge clock_in);
    endtask

    // ----------------------------------------------------------------
    // output watcher
    // ----------------------------------------------------------------
    initial forever begin
        note_t n;
        @(chk_ev);
        n = notes.pop_front();
        check(nm[n.idx], outs[n.idx], n.val);
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 12000) begin
            num_errors++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial begin
        {rst_b_in, rail1_on_in, rail2_on_in, run, r1m} = 5'h00;
        {rail1_good_in, supply_sense_in, keep_on_n_in, wdog_off_n_in} = 4'hf;
        {window_select_lo_in, window_select_hi_in} = 2'h0;
        {wdog_period_sel_in, rst_period_sel_in} = {SEL_ADJ, SEL_ADJ};
        wdog_adj_ticks_in = 12'h00a;
        rst_adj_ticks_in = 12'h005;
        gap = 8'h30;
        void'($urandom(32'h7593c456));
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        tk(3); expect_out(0, 1'b0);
        tk(4); expect_out(0, 1'b1);
        $display("test reset timeout done");
        gap <= 8'h20 + 8'($urandom_range(0, 40));
        run <= 1'b1;
        tk(30); expect_out(0, 1'b1);
        expect_out(4, 1'b1);
        $display("test serviced watchdog done");
        run <= 1'b0;
        wait_low(); expect_out(0, 1'b0);
        tk(2); expect_out(0, 1'b0);
        tk(5); expect_out(0, 1'b1);
        tk(6); expect_out(0, 1'b1);
        tk(6); expect_out(0, 1'b0);
        run <= 1'b1;
        tk(8); expect_out(0, 1'b1);
        $display("test pulse train done");
        wdog_off_n_in <= 1'b0;
        window_select_lo_in <= 1'b1;
        run <= 1'b0;
        tk(15); expect_out(0, 1'b1);
        expect_out(4, 1'b1);
        {wdog_off_n_in, wdog_period_sel_in} <= {1'b1, SEL_GND};
        window_select_lo_in <= 1'b0;
        wdog_adj_ticks_in <= 12'h00c;
        tk(15); expect_out(0, 1'b1);
        expect_out(4, 1'b1);
        $display("test disables done");
        {window_select_hi_in, window_select_lo_in, wdog_period_sel_in} <= {2'h3, SEL_ADJ};
        gap <= 8'h02;
        run <= 1'b1;
        tk(3); expect_out(4, 1'b1);
        window_select_hi_in <= 1'b0;
        window_select_lo_in <= 1'b0;
        tk(1); expect_out(4, 1'b0);
        expect_out(0, 1'b1);
        gap <= 8'h30;
        run <= 1'b0;
        tk(8); expect_out(4, 1'b1);
        $display("test window done");
        rail1_good_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        expect_out(0, 1'b0);
        {rail1_good_in, rst_period_sel_in} <= {1'b1, SEL_GND};
        rst_adj_ticks_in <= 12'h004;
        tk(10); expect_out(0, 1'b0);
        rst_period_sel_in <= SEL_ADJ;
        tk(8); expect_out(0, 1'b1);
        {rail1_good_in, rst_period_sel_in, wdog_period_sel_in} <= {1'b0, SEL_FIXED, SEL_FIXED};
        repeat (5) @(posedge clock_in);
        rail1_good_in <= 1'b1;
        tk(190); expect_out(0, 1'b0);
        tk(15); expect_out(0, 1'b1);
        $display("test rail monitor done");
        for (int k = 0; k < 40; k++) begin
            {rail1_on_in, rail2_on_in, keep_on_n_in} <= 3'($urandom());
            @(posedge clock_in);
            r1m = rail1_on_in | (r1m & ~keep_on_n_in);
            repeat (4) @(posedge clock_in);
            expect_out(1, r1m);
            expect_out(2, rail2_on_in);
        end
        $display("test rails done");
        supply_sense_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        expect_out(3, 1'b1);
        repeat (6) @(posedge clock_in);
        expect_out(3, 1'b0);
        supply_sense_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        supply_sense_in <= 1'b0;
        repeat (14) @(posedge clock_in);
        expect_out(3, 1'b0);
        supply_sense_in <= 1'b1;
        repeat (14) @(posedge clock_in);
        expect_out(3, 1'b1);
        $display("test supply flag done");
        wrap_up();
    end
endmodule
`default_nettype wire
